// File: src/rf_cfg_decoder.sv
// SPI command decoder and configuration store of the FSK transceiver
//
// What this block does
// - Decode 1001100 prefix as transmit configuration
// - Polarity one puts data zero low
// - Deviation equals code plus one times 15k
// - Deviation sign is polarity XOR data
// - Power code selects attenuation, 2.5 dB steps except code 4 at 10.5 dB
// - Upper byte 10111000 writes transmit byte
// - Top nibble 1010 sets center frequency
// - Out-of-range frequency values are ignored
// - Frequency word from band offset and value; band factor only shown in cfg_o
// - Prefix 10010 is receive control
// - Bit 10 picks indicator output or interrupt
// - Two bits pick indicator response time
// - Three-bit code sets baseband bandwidth
// - Two-bit code sets LNA gain reduction
// - Signal strength threshold gates data quality
// - Byte 11000010 is baseband filter command
// - Auto lock starts fast, goes slow
// - Filter type bit selects analog or digital
// - Manual sample stores offset when enabled
// - Configuration words start with a one
// - Register transmission only when enabled
`timescale 1ns/1ps
`default_nettype none
module rf_cfg_decoder
  import rf_cfg_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic spi_sck_i,
  input wire logic spi_cs_b_i,
  input wire logic spi_sdi_i,
  input wire logic tx_modulation_input_pin_i,
  input wire logic bit_tick_i,
  input wire logic signal_above_i,
  input wire logic quality_raw_i,
  input wire logic clock_locked_i,
  input wire logic [4:0] afc_offset_i,
  output logic [15:0] transmit_configuration_o,
  output logic [15:0] transmit_byte_o,
  output logic [15:0] center_frequency_o,
  output logic [15:0] receive_control_o,
  output logic [15:0] baseband_filter_config_o,
  output cfg_view_s cfg_o,
  output logic [7:0] deviation_khz_o,
  output logic [5:0] atten_half_db_o,
  output logic [8:0] bandwidth_khz_o,
  output logic [4:0] lna_reduction_db_o,
  output logic [6:0] rssi_thr_neg_db_o,
  output logic [1:0] indicator_mode_o,
  output logic indicator_is_output_o,
  output logic tx_active_o,
  output logic tx_data_bit_o,
  output logic dev_sign_neg_o,
  output logic data_quality_status_o,
  output logic recovery_fast_o,
  output logic [4:0] pll_offset_o,
  output logic [13:0] freq_word_o,
  output logic word_dropped_o
);
  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [2:0] sck_sync;
    logic [1:0] cs_sync;
    logic [1:0] sdi_sync;
    logic [1:0] fsk_sync;
    frame_e frame;
    logic [15:0] shift;
    logic [4:0] count;
    logic [15:0] txcfg;
    logic [15:0] txbyte;
    logic [15:0] cfreq;
    logic [15:0] rxctl;
    logic [15:0] bbf;
    logic [15:0] gen;
    logic [15:0] afc;
    logic [7:0] tx_shreg;
    logic [2:0] tx_idx;
    logic auto_slow;
    logic strobe_seen;
    logic [4:0] offset;
    logic dropped;
  } state_s;

  state_s q;
  state_s next_q;

  logic sck_rise;
  logic push_valid;
  logic push_ready;
  logic [15:0] cmd_word;
  logic cmd_valid;
  logic fsk_in;
  logic tx_bit;

  function automatic logic is_cmd(input logic [15:0] w, input int nbits,
                                  input logic [7:0] code);
    logic [7:0] top;
    top = w[15:8] >> (8 - nbits);
    return top == (code & ((8'h01 << nbits) - 8'h01));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Word buffer between the SPI frame and the register decode
  rf_word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(push_valid),
    .in_ready_o(push_ready),
    .in_data_i(q.shift),
    .out_valid_o(cmd_valid),
    .out_ready_i(1'b1),
    .out_data_o(cmd_word)
  );

  // Only stage 2 and 3 are looked at; stage 1 feeds stage 2 alone
  assign sck_rise = q.sck_sync[1] && !q.sck_sync[2];
  assign fsk_in = q.fsk_sync[1];
  assign push_valid = (q.frame == ST_APPLY) && (q.count == 5'd16);

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_q = q;
    next_q.sck_sync = {q.sck_sync[1:0], spi_sck_i};
    next_q.cs_sync = {q.cs_sync[0], spi_cs_b_i};
    next_q.sdi_sync = {q.sdi_sync[0], spi_sdi_i};
    next_q.fsk_sync = {q.fsk_sync[0], tx_modulation_input_pin_i};
    next_q.dropped = 1'b0;
    // Tick first so that a byte load in the same cycle wins
    if (bit_tick_i && q.gen[TX_DATA_REGISTER_ENABLE_BIT]) begin
      next_q.tx_shreg = {q.tx_shreg[6:0], q.tx_shreg[7]};
      next_q.tx_idx = q.tx_idx - 3'd1;
    end
    case (q.frame)
      ST_IDLE: begin
        if (!q.cs_sync[1]) begin
          next_q.frame = ST_SHIFT;
          next_q.count = '0;
        end
      end
      ST_SHIFT: begin
        if (q.cs_sync[1]) begin
          next_q.frame = ST_APPLY;
        end else if (sck_rise && q.count != 5'd16) begin
          next_q.shift = {q.shift[14:0], q.sdi_sync[1]};
          next_q.count = q.count + 5'd1;
        end
      end
      ST_APPLY: begin
        next_q.frame = ST_IDLE;
        next_q.dropped = push_valid && !push_ready;
      end
      default: begin
        next_q.frame = ST_IDLE;
      end
    endcase
    // Status read words start with zero and change nothing here
    if (cmd_valid && cmd_word[15]) begin
      if (is_cmd(cmd_word, 7, {1'b0, CMD_TXCFG})) begin
        next_q.txcfg = cmd_word;
      end else if (is_cmd(cmd_word, 8, CMD_TXBYTE)) begin
        next_q.txbyte = cmd_word;
        next_q.tx_shreg = cmd_word[7:0];
        next_q.tx_idx = 3'd7;
      end else if (is_cmd(cmd_word, 4, {4'h0, CMD_CFREQ})) begin
        if (cmd_word[11:0] >= FREQ_MIN && cmd_word[11:0] <= FREQ_MAX) begin
          next_q.cfreq = cmd_word;
        end
      end else if (is_cmd(cmd_word, 5, {3'h0, CMD_RXCTL})) begin
        next_q.rxctl = cmd_word;
      end else if (is_cmd(cmd_word, 8, CMD_BBF)) begin
        // Reserved ones forced so a careless write stays sane
        next_q.bbf = cmd_word | BBF_RSVD_ONES;
      end else if (is_cmd(cmd_word, 8, CMD_GEN)) begin
        next_q.gen = cmd_word;
      end else if (is_cmd(cmd_word, 8, CMD_AFC)) begin
        next_q.afc = cmd_word;
      end
    end
    // Auto lock: fast until locked, then slow; unlock goes fast again
    next_q.auto_slow = q.bbf[AUTO_LOCK_CONTROL_BIT] && clock_locked_i;
    // One capture per strobe; strobe must drop before the next
    if (q.afc[MANUAL_SAMPLE_STROBE_BIT] && !q.strobe_seen) begin
      next_q.strobe_seen = 1'b1;
      if (q.afc[OFFSET_STORAGE_ENABLE_BIT]) begin
        next_q.offset = afc_offset_i;
      end
    end else if (!q.afc[MANUAL_SAMPLE_STROBE_BIT]) begin
      next_q.strobe_seen = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '{sck_sync: 3'h0, cs_sync: 2'h3, sdi_sync: 2'h0,
             fsk_sync: 2'h0, frame: ST_IDLE, shift: 16'h0000,
             count: 5'h00, txcfg: RST_TXCFG, txbyte: RST_TXBYTE,
             cfreq: RST_CFREQ, rxctl: RST_RXCTL, bbf: RST_BBF,
             gen: RST_GEN, afc: RST_AFC, tx_shreg: 8'haa, tx_idx: 3'h7,
             auto_slow: 1'b0, strobe_seen: 1'b0, offset: 5'h00,
             dropped: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign transmit_configuration_o = q.txcfg;
  assign transmit_byte_o = q.txbyte;
  assign center_frequency_o = q.cfreq;
  assign receive_control_o = q.rxctl;
  assign baseband_filter_config_o = q.bbf;
  assign word_dropped_o = q.dropped;
  assign pll_offset_o = q.afc[OFFSET_STORAGE_ENABLE_BIT] ? q.offset : 5'h00;

  always_comb begin
    cfg_o.pol = q.txcfg[POL_BIT];
    cfg_o.dev_code = q.txcfg[7:4];
    cfg_o.pwr_code = q.txcfg[2:0];
    cfg_o.tx_byte = q.txbyte[7:0];
    cfg_o.freq_value = q.cfreq[11:0];
    case (q.gen[5:4])
      2'b10: begin
        cfg_o.band_factor = FA1_868;
        cfg_o.band_offset = FA0_LOW;
      end
      2'b11: begin
        cfg_o.band_factor = FA1_915;
        cfg_o.band_offset = FA0_915;
      end
      default: begin
        cfg_o.band_factor = FA1_433;
        cfg_o.band_offset = FA0_LOW;
      end
    endcase
    cfg_o.pin_func = q.rxctl[PINF_BIT];
    cfg_o.resp_time = q.rxctl[9:8];
    cfg_o.bw_code = q.rxctl[7:5];
    cfg_o.lna_code = q.rxctl[4:3];
    cfg_o.rssi_thr = q.rxctl[2:0];
    cfg_o.auto_lock = q.bbf[AUTO_LOCK_CONTROL_BIT];
    cfg_o.manual_fast = q.bbf[MANUAL_LOCK_SPEED_BIT];
    cfg_o.filter_analog = q.bbf[FILTER_TYPE_BIT];
    cfg_o.quality_thr = q.bbf[2:0];
    cfg_o.tx_reg_en = q.gen[TX_DATA_REGISTER_ENABLE_BIT];
    cfg_o.offset_store_en = q.afc[OFFSET_STORAGE_ENABLE_BIT];
  end

  // Frequency word is band offset scaled by the divider plus value
  assign freq_word_o = 14'(int'(cfg_o.band_offset) * FREQ_DIV / 100)
                       + {2'b00, q.cfreq[11:0]};
  assign deviation_khz_o = 8'((int'(q.txcfg[7:4]) + 1) * DEV_STEP_KHZ);

  always_comb begin
    case (q.txcfg[2:0])
      3'd4: atten_half_db_o = 6'd21;
      default: atten_half_db_o = 6'(int'(q.txcfg[2:0]) * 5);
    endcase
    case (q.rxctl[7:5])
      3'd1: bandwidth_khz_o = 9'd400;
      3'd2: bandwidth_khz_o = 9'd340;
      3'd3: bandwidth_khz_o = 9'd270;
      3'd4: bandwidth_khz_o = 9'd200;
      3'd5: bandwidth_khz_o = 9'd134;
      3'd6: bandwidth_khz_o = 9'd67;
      default: bandwidth_khz_o = 9'd0;
    endcase
    case (q.rxctl[4:3])
      2'd1: lna_reduction_db_o = 5'd6;
      2'd2: lna_reduction_db_o = 5'd14;
      2'd3: lna_reduction_db_o = 5'd20;
      default: lna_reduction_db_o = 5'd0;
    endcase
    // Reserved threshold codes read as zero
    if (q.rxctl[2:0] <= 3'd5) begin
      rssi_thr_neg_db_o = 7'(103 - 6 * int'(q.rxctl[2:0]));
    end else begin
      rssi_thr_neg_db_o = 7'd0;
    end
  end

  assign indicator_is_output_o = q.rxctl[PINF_BIT];
  assign indicator_mode_o = q.rxctl[PINF_BIT] ? q.rxctl[9:8] : 2'b00;
  assign tx_active_o = q.gen[TX_DATA_REGISTER_ENABLE_BIT];
  assign tx_bit = q.gen[TX_DATA_REGISTER_ENABLE_BIT] ? q.tx_shreg[7] : fsk_in;
  assign tx_data_bit_o = tx_bit;
  // Sign 1 means lower frequency: polarity one sends zero low
  assign dev_sign_neg_o = q.txcfg[POL_BIT] ^ tx_bit;
  assign data_quality_status_o = quality_raw_i && signal_above_i
                                 && q.rxctl[2:0] <= 3'd5;
  assign recovery_fast_o = q.bbf[AUTO_LOCK_CONTROL_BIT] ? !q.auto_slow
                           : q.bbf[MANUAL_LOCK_SPEED_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  freq_range_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    q.cfreq[11:0] >= FREQ_MIN && q.cfreq[11:0] <= FREQ_MAX)
    else $error("center frequency out of window");
  sign_xor_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    dev_sign_neg_o == (q.txcfg[POL_BIT] ^ tx_data_bit_o))
    else $error("deviation sign mismatch");
  bbf_rsvd_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (q.bbf & BBF_RSVD_ONES) == BBF_RSVD_ONES)
    else $error("filter reserved bits lost");
  txcfg_load_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    cmd_valid && cmd_word[15:9] == CMD_TXCFG |=> q.txcfg == $past(cmd_word))
    else $error("transmit configuration not loaded");
  txbyte_load_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    cmd_valid && cmd_word[15:8] == CMD_TXBYTE |=> q.txbyte == $past(cmd_word))
    else $error("transmit byte not loaded");
  rxctl_load_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    cmd_valid && cmd_word[15:11] == CMD_RXCTL |=> q.rxctl == $past(cmd_word))
    else $error("receive control not loaded");
  dev_value_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    q.txcfg[7:4] == 4'hf |-> deviation_khz_o == 8'd240)
    else $error("deviation at top code wrong");
  tx_idle_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !q.gen[TX_DATA_REGISTER_ENABLE_BIT] |-> tx_data_bit_o == q.fsk_sync[1])
    else $error("register transmit while disabled");
  apply_push_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    q.frame == ST_SHIFT && q.cs_sync[1] && q.count == 5'd16
    |=> push_valid)
    else $error("full word not applied at deselect");
  auto_lock_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    q.bbf[AUTO_LOCK_CONTROL_BIT] && !clock_locked_i ##1 q.bbf[AUTO_LOCK_CONTROL_BIT]
    |-> recovery_fast_o)
    else $error("auto lock not fast before lock");
  auto_slow_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    q.bbf[AUTO_LOCK_CONTROL_BIT] && clock_locked_i ##1 q.bbf[AUTO_LOCK_CONTROL_BIT]
    |-> !recovery_fast_o) else $error("auto lock not slow after lock");
  cfreq_load_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    cmd_valid && cmd_word[15:12] == CMD_CFREQ && cmd_word[11:0] >= FREQ_MIN
    && cmd_word[11:0] <= FREQ_MAX |=> q.cfreq == $past(cmd_word))
    else $error("center frequency not loaded");
  cfreq_keep_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    cmd_valid && cmd_word[15:12] == CMD_CFREQ && (cmd_word[11:0] < FREQ_MIN
    || cmd_word[11:0] > FREQ_MAX) |=> $stable(q.cfreq))
    else $error("out of window frequency taken");
  bbf_load_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    cmd_valid && cmd_word[15:8] == CMD_BBF
    |=> q.bbf == ($past(cmd_word) | BBF_RSVD_ONES))
    else $error("filter config not loaded");
  zero_lead_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    cmd_valid && !cmd_word[15] |=> $stable(q.txcfg) && $stable(q.rxctl)
    && $stable(q.cfreq) && $stable(q.bbf) && $stable(q.txbyte))
    else $error("zero lead word changed a register");
  shreg_load_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    cmd_valid && cmd_word[15:8] == CMD_TXBYTE
    |=> q.tx_shreg == $past(cmd_word[7:0]))
    else $error("transmit shifter not loaded");
  shreg_hold_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    !q.gen[TX_DATA_REGISTER_ENABLE_BIT] && !(cmd_valid && cmd_word[15:8] == CMD_TXBYTE)
    |=> $stable(q.tx_shreg)) else $error("shifter moved while disabled");
  offset_take_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    q.afc[MANUAL_SAMPLE_STROBE_BIT] && !q.strobe_seen && q.afc[OFFSET_STORAGE_ENABLE_BIT]
    |=> q.offset == $past(afc_offset_i)) else $error("offset not captured");
  ind_mode_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    !q.rxctl[PINF_BIT] |-> indicator_mode_o == 2'b00)
    else $error("response time shown on interrupt pin");
endmodule
`default_nettype wire

// File: src/rf_cfg_pkg.sv
// Shared constants and carrier types of the transceiver command decoder
package rf_cfg_pkg;
  localparam int WORD_W = 16;
  // Command codes and their widths
  localparam logic [6:0] CMD_TXCFG = 7'h4c;
  localparam logic [7:0] CMD_TXBYTE = 8'hb8;
  localparam logic [3:0] CMD_CFREQ = 4'ha;
  localparam logic [4:0] CMD_RXCTL = 5'h12;
  localparam logic [7:0] CMD_BBF = 8'hc2;
  localparam logic [7:0] CMD_GEN = 8'h80;
  localparam logic [7:0] CMD_AFC = 8'hc4;
  // Power-on values
  localparam logic [15:0] RST_TXCFG = 16'h9800;
  localparam logic [15:0] RST_TXBYTE = 16'hb8aa;
  localparam logic [15:0] RST_CFREQ = 16'ha680;
  localparam logic [15:0] RST_RXCTL = 16'h9080;
  localparam logic [15:0] RST_BBF = 16'hc22c;
  localparam logic [15:0] RST_GEN = 16'h8008;
  localparam logic [15:0] RST_AFC = 16'hc4f7;
  // Frequency window
  localparam logic [11:0] FREQ_MIN = 12'h060;
  localparam logic [11:0] FREQ_MAX = 12'hf3f;
  // Field positions
  localparam int POL_BIT = 8;
  localparam int TX_DATA_REGISTER_ENABLE_BIT = 7;
  localparam int OFFSET_STORAGE_ENABLE_BIT = 1;
  localparam int MANUAL_SAMPLE_STROBE_BIT = 3;
  localparam int AUTO_LOCK_CONTROL_BIT = 7;
  localparam int MANUAL_LOCK_SPEED_BIT = 6;
  localparam int FILTER_TYPE_BIT = 4;
  localparam int PINF_BIT = 10;
  localparam logic [15:0] BBF_RSVD_ONES = 16'h0028;
  // Band factor and offset, indexed by band select
  localparam logic [1:0] FA1_433 = 2'h1;
  localparam logic [1:0] FA1_868 = 2'h2;
  localparam logic [1:0] FA1_915 = 2'h3;
  localparam logic [5:0] FA0_LOW = 6'h2b;
  localparam logic [5:0] FA0_915 = 6'h1e;
  localparam int FREQ_DIV = 4000;
  localparam int DEV_STEP_KHZ = 15;
  // Clock rates
  localparam int CLK_SYS_HZ = 20_000_000;
  localparam int CLK_LINK_HZ = 2_500_000;
  localparam int BIT_CYC = CLK_SYS_HZ / CLK_LINK_HZ;

  typedef struct packed {
    logic pol;
    logic [3:0] dev_code;
    logic [2:0] pwr_code;
    logic [7:0] tx_byte;
    logic [11:0] freq_value;
    logic [1:0] band_factor;
    logic [5:0] band_offset;
    logic pin_func;
    logic [1:0] resp_time;
    logic [2:0] bw_code;
    logic [1:0] lna_code;
    logic [2:0] rssi_thr;
    logic auto_lock;
    logic manual_fast;
    logic filter_analog;
    logic [2:0] quality_thr;
    logic tx_reg_en;
    logic offset_store_en;
  } cfg_view_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_APPLY = 3'b100
  } frame_e;
endpackage

// File: src/rf_word_fifo.sv
// Parameterised valid/ready FIFO for received command words
`timescale 1ns/1ps
`default_nettype none
module rf_word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;
  assign in_ready_o = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_ptr != rd_ptr;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end
endmodule
`default_nettype wire

// File: tb/rf_cfg_decoder_tb.sv
// Self-checking bench of the transceiver command decoder
`timescale 1ns/1ps
`default_nettype none
module rf_cfg_decoder_tb
  import rf_cfg_pkg::*;
;
  logic clk_sys, rst_b, sck, cs_b, sdi, mod_pin, sig_above, qual_raw, locked;
  logic bit_tick = 1'b0;
  logic [4:0] afc_off, ofs;
  logic [15:0] tcfg, tbyte, cfreq, rxctl, bbf, w, etc, expf, boff;
  cfg_view_s cfg;
  logic [7:0] dev_khz;
  logic [5:0] atten;
  logic [8:0] bw_khz;
  logic [4:0] lna_db, pll_off;
  logic [6:0] rssi_db;
  logic [1:0] ind_mode, rt;
  logic ind_out, tx_act, tx_bit, sign_neg, dq, rec_fast, pol, pf;
  logic [13:0] fword;
  logic [7:0] got;
  int seed, cycles, fail_count, comparisons;
  logic [11:0] fv [6] = '{12'd95, 12'd96, 12'd3903, 12'd3904, 12'd0, 12'd4095};

  spi_host_model u_spi_host_model (.clk_sys_i(clk_sys), .spi_sck_o(sck),
    .spi_cs_b_o(cs_b), .spi_sdi_o(sdi));

  rf_cfg_decoder #(.FIFO_DEPTH(16)) u_rf_cfg_decoder (
    .clk_sys_i(clk_sys), .rst_b_i(rst_b), .spi_sck_i(sck),
    .spi_cs_b_i(cs_b), .spi_sdi_i(sdi), .tx_modulation_input_pin_i(mod_pin),
    .bit_tick_i(bit_tick), .signal_above_i(sig_above),
    .quality_raw_i(qual_raw), .clock_locked_i(locked),
    .afc_offset_i(afc_off), .transmit_configuration_o(tcfg),
    .transmit_byte_o(tbyte), .center_frequency_o(cfreq),
    .receive_control_o(rxctl), .baseband_filter_config_o(bbf),
    .cfg_o(cfg), .deviation_khz_o(dev_khz), .atten_half_db_o(atten),
    .bandwidth_khz_o(bw_khz), .lna_reduction_db_o(lna_db),
    .rssi_thr_neg_db_o(rssi_db), .indicator_mode_o(ind_mode),
    .indicator_is_output_o(ind_out), .tx_active_o(tx_act),
    .tx_data_bit_o(tx_bit), .dev_sign_neg_o(sign_neg),
    .data_quality_status_o(dq), .recovery_fast_o(rec_fast),
    .pll_offset_o(pll_off), .freq_word_o(fword), .word_dropped_o());

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 15000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // Transmit bit pacing, one pulse every 8 cycles
  always @(negedge clk_sys) bit_tick <= (cycles[2:0] == 3'h0);

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic send(input logic [15:0] word);
    u_spi_host_model.send_word(word, 16);
  endtask

  function automatic logic [15:0] atten_exp(input logic [2:0] c);
    return (c == 3'h4) ? 16'd21 : 16'(c) * 16'd5;
  endfunction

  // True when g is some rotation of b; the start phase is not known
  function automatic logic rot_match(input logic [7:0] b,
                                     input logic [7:0] g);
    logic [15:0] d;
    d = {b, b};
    for (int k = 0; k < 8; k++)
      if (d[k +: 8] == g) return 1'b1;
    return 1'b0;
  endfunction

  function automatic logic [15:0] bw_exp(input logic [2:0] c);
    case (c)
      3'h1: return 16'd400;
      3'h2: return 16'd340;
      3'h3: return 16'd270;
      3'h4: return 16'd200;
      3'h5: return 16'd134;
      3'h6: return 16'd67;
      default: return 16'd0;
    endcase
  endfunction

  function automatic logic [15:0] lna_exp(input logic [1:0] c);
    case (c)
      2'h0: return 16'd0;
      2'h1: return 16'd6;
      2'h2: return 16'd14;
      default: return 16'd20;
    endcase
  endfunction

  function automatic logic [15:0] rssi_exp(input logic [2:0] c);
    return (c > 3'h5) ? 16'd0 : 16'd103 - 16'(c) * 16'd6;
  endfunction

  task automatic freq(input logic [11:0] v);
    send({CMD_CFREQ, v});
    if (v >= 12'd96 && v <= 12'd3903)
      expf = {CMD_CFREQ, v};
    check("center frequency", expf, cfreq);
    check("freq word", boff * 16'd40 + 16'(expf[11:0]), 16'(fword));
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 11133;
    {mod_pin, sig_above, qual_raw, locked, rst_b} = 5'h00;
    afc_off = 5'h00;
    expf = RST_CFREQ;
    etc = RST_TXCFG;
    boff = 16'd43;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (3) @(negedge clk_sys);
    check("txcfg reset", RST_TXCFG, tcfg);
    check("txbyte reset", RST_TXBYTE, tbyte);
    check("cfreq reset", RST_CFREQ, cfreq);
    check("rxctl reset", RST_RXCTL, rxctl);
    check("bbf reset", RST_BBF, bbf);
    for (int i = 0; i < 16; i++) begin
      pol = 1'($random(seed));
      w = {CMD_TXCFG, pol, 4'(i), 1'b0, 3'(i)};
      send(w);
      etc = w;
      check("tx config", w, tcfg);
      check("deviation", 16'((i + 1) * 15), 16'(dev_khz));
      check("attenuation", atten_exp(3'(i)), 16'(atten));
      mod_pin = 1'($random(seed));
      repeat (4) @(negedge clk_sys);
      check("pin data bit", 16'(mod_pin), 16'(tx_bit));
      check("dev sign", 16'(pol ^ mod_pin), 16'(sign_neg));
    end
    for (int i = 0; i < 6; i++)
      freq(fv[i]);
    freq(12'(96 + ($random(seed) & 2047)));
    send(16'h80b8);
    boff = 16'd30;
    check("tx enable", 16'h0001, 16'(tx_act));
    freq(12'd3000);
    w = {CMD_TXBYTE, 8'($random(seed))};
    send(w);
    check("tx byte", w, tbyte);
    check("tx byte field", 16'(w[7:0]), 16'(cfg.tx_byte));
    for (int k = 0; k < 8; k++) begin
      do @(posedge clk_sys); while (!bit_tick);
      @(negedge clk_sys);
      got = {got[6:0], tx_bit};
    end
    check("tx byte bits", 16'h0001, 16'(rot_match(w[7:0], got)));
    repeat (20) @(negedge clk_sys);
    check("reg dev sign", 16'(pol ^ tx_bit), 16'(sign_neg));
    for (int i = 0; i < 8; i++) begin
      pf = 1'($random(seed));
      rt = 2'($random(seed));
      w = {CMD_RXCTL, pf, rt, i[2:0], i[1:0], 3'(7 - i)};
      send(w);
      check("rx control", w, rxctl);
      check("indicator dir", 16'(pf), 16'(ind_out));
      check("indicator time", pf ? 16'(rt) : 16'h0000, 16'(ind_mode));
      check("bandwidth", bw_exp(i[2:0]), 16'(bw_khz));
      check("lna", lna_exp(i[1:0]), 16'(lna_db));
      check("rssi thr", rssi_exp(3'(7 - i)), 16'(rssi_db));
    end
    for (int i = 0; i < 4; i++) begin
      sig_above = 1'($random(seed));
      qual_raw = 1'($random(seed));
      repeat (3) @(negedge clk_sys);
      check("quality", 16'(sig_above & qual_raw), 16'(dq));
    end
    for (int i = 0; i < 4; i++) begin
      // Threshold kept below four, reserved bits written as ones
      w = {CMD_BBF, i[1], i[0], 1'b1, 1'($random(seed)), 1'b1, 3'(i)};
      locked = 1'b0;
      send(w);
      check("bbf", w, bbf);
      check("filter type", 16'(w[4]), 16'(cfg.filter_analog));
      check("recovery", i[1] ? 16'h0001 : 16'(i[0]), 16'(rec_fast));
      // Lock only after a preamble of 16 link bit periods
      repeat (128) @(negedge clk_sys);
      locked = 1'b1;
      repeat (4) @(negedge clk_sys);
      check("locked rec", i[1] ? 16'h0000 : 16'(i[0]), 16'(rec_fast));
    end
    afc_off = 5'($random(seed));
    ofs = afc_off;
    send(16'hc40a);
    check("afc offset", 16'(ofs), 16'(pll_off));
    afc_off = ~ofs;
    send(16'hc402);
    check("afc held", 16'(ofs), 16'(pll_off));
    send(16'hc400);
    check("afc off", 16'h0000, 16'(pll_off));
    send(16'h1955);
    check("zero lead", etc, tcfg);
    u_spi_host_model.send_word(16'h9955, 15);
    check("short word", etc, tcfg);
    check("freq kept", expf, cfreq);
    tally_and_finish();
  end
endmodule
`default_nettype wire

// File: tb/spi_host_model.sv
// Host side of the serial command port: shifts words into the decoder
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input wire logic clk_sys_i,
  output logic spi_sck_o,
  output logic spi_cs_b_o,
  output logic spi_sdi_o
);
  initial begin
    spi_sck_o = 1'b0;
    spi_cs_b_o = 1'b1;
    spi_sdi_o = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Half period of 4 system cycles gives the 400 ns link clock
  task automatic send_word(input logic [15:0] word, input int nbits);
    @(negedge clk_sys_i);
    spi_cs_b_o = 1'b0;
    for (int i = 15; i > 15 - nbits; i--) begin
      spi_sdi_o = word[i];
      repeat (4) @(negedge clk_sys_i);
      spi_sck_o = 1'b1;
      repeat (4) @(negedge clk_sys_i);
      spi_sck_o = 1'b0;
    end
    repeat (4) @(negedge clk_sys_i);
    spi_cs_b_o = 1'b1;
    // Released line shows no stale bit
    spi_sdi_o = ~spi_sdi_o;
    // Gap covers sync, apply and load latency
    repeat (10) @(negedge clk_sys_i);
  endtask
endmodule
`default_nettype wire
